// [hw/pml_defines.vh]
// Overview of operation
// - crs and col follow tx enable quickly
// - gigabit start delimiter 76 to 84 ns
// - gigabit end code 76 to 84 ns
// - two-bit latency field adds 8 ns steps
// - end bounds assume no frequency offset
// - 100 Mb/s delimiters 64 to 72 ns
// - 10 Mb/s preamble and end 200-300 ns
// - gigabit rx crs/col and dv assert timing
// - gigabit rx crs/col and dv drop timing
// - gigabit rx assert timed from last pair, drop from first pair
// - 100 Mb/s rx crs/col and dv assert
`ifndef PML_DEFINES_VH
`define PML_DEFINES_VH

`define PML_CLK_NS 8
`define PML_CEIL_CYC(ns) (((ns) + `PML_CLK_NS - 1) / `PML_CLK_NS)
`define PML_FLOOR_CYC(ns) ((ns) / `PML_CLK_NS)

// speed codes
`define PML_SPEED_10 2'h0
`define PML_SPEED_100 2'h1
`define PML_SPEED_1000 2'h2

// end-of-stream code kinds on the line
`define PML_END_RESET 2'h0
`define PML_END_EXTEND 2'h1
`define PML_END_EXT_ERR 2'h2
`define PML_TXD_EXT_ERR 8'h1F

// transmit side
`define PML_TX_CRS_MAX_NS 16
`define PML_TX_CRS_CYC `PML_FLOOR_CYC(`PML_TX_CRS_MAX_NS)
`define PML_TX_1000_MIN_NS 76
`define PML_TX_1000_CYC `PML_CEIL_CYC(`PML_TX_1000_MIN_NS)
`define PML_TX_100_MIN_NS 64
`define PML_TX_100_CYC `PML_CEIL_CYC(`PML_TX_100_MIN_NS)
`define PML_TX_10_MIN_NS 200
`define PML_TX_10_CYC `PML_CEIL_CYC(`PML_TX_10_MIN_NS)
`define PML_LAT_STEP_NS 8
`define PML_LAT_STEP_CYC `PML_CEIL_CYC(`PML_LAT_STEP_NS)
`define PML_LAT_RESET 2'h0

// receive side, gigabit
`define PML_RX1G_CRS_ON_NS 156
`define PML_RX1G_CRS_ON_CYC `PML_CEIL_CYC(`PML_RX1G_CRS_ON_NS)
`define PML_RX1G_CRS_OFF_NS 172
`define PML_RX1G_CRS_OFF_CYC `PML_CEIL_CYC(`PML_RX1G_CRS_OFF_NS)
`define PML_RX1G_DV_ON_NS 176
`define PML_RX1G_DV_ON_CYC `PML_CEIL_CYC(`PML_RX1G_DV_ON_NS)
`define PML_RX1G_DV_OFF_NS 176
`define PML_RX1G_DV_OFF_CYC `PML_CEIL_CYC(`PML_RX1G_DV_OFF_NS)

// receive side, 100 Mb/s
`define PML_RX100_CRS_ON_NS 152
`define PML_RX100_CRS_ON_CYC `PML_CEIL_CYC(`PML_RX100_CRS_ON_NS)
`define PML_RX100_CRS_OFF_NS 192
`define PML_RX100_CRS_OFF_CYC `PML_CEIL_CYC(`PML_RX100_CRS_OFF_NS)
`define PML_RX100_DV_ON_NS 216
`define PML_RX100_DV_ON_CYC `PML_CEIL_CYC(`PML_RX100_DV_ON_NS)
`define PML_RX100_DV_OFF_NS 216
`define PML_RX100_DV_OFF_CYC `PML_CEIL_CYC(`PML_RX100_DV_OFF_NS)

// receive data pacing toward the mac, in clocks per word minus one
`define PML_PACE_100 6'h04
`define PML_PACE_10 6'h31

`endif

// [hw/pml_fifo.v]
`timescale 1ns/10ps
module pml_fifo #(
  parameter W  = 8,
  parameter D  = 4,
  parameter AW = 2
) (
  input  wire         clk_i,
  input  wire         srst_i,
  input  wire         ce_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  function [AW:0] pml_fit;
    input integer v;
    begin
      pml_fit = v[AW:0];
    end
  endfunction

  localparam [AW:0] DEPTH_C = pml_fit(D);
  localparam [AW:0] LAST_C  = pml_fit(D - 1);

  reg [W-1:0]  mem_q [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  reg [AW:0]   cnt_d;
  reg          in_ready_q;
  reg          out_valid_q;
  wire         push;
  wire         pop;

  function [AW-1:0] pml_inc;
    input [AW-1:0] p;
    begin
      pml_inc = ({1'b0, p} == LAST_C) ? {AW{1'b0}} : p + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  assign push        = ce_i & in_valid_i & in_ready_q;
  assign pop         = ce_i & out_valid_q & out_ready_i;
  assign in_ready_o  = in_ready_q;
  assign out_valid_o = out_valid_q;
  assign out_data_o  = mem_q[rd_q];

  always @* begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + {{AW{1'b0}}, 1'b1};
    end else if (pop & ~push) begin
      cnt_d = cnt_q - {{AW{1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // flags are registered so the top sees flop-driven ready and valid
  always @(posedge clk_i) begin
    if (srst_i) begin
      wr_q        <= {AW{1'b0}};
      rd_q        <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      in_ready_q  <= 1'b1;
      out_valid_q <= 1'b0;
    end else if (ce_i) begin
      if (push) begin
        wr_q <= pml_inc(wr_q);
      end
      if (pop) begin
        rd_q <= pml_inc(rd_q);
      end
      cnt_q       <= cnt_d;
      in_ready_q  <= (cnt_d != DEPTH_C);
      out_valid_q <= (cnt_d != {(AW+1){1'b0}});
    end
  end
endmodule // pml_fifo

// [hw/pml_top.v]
`timescale 1ns/10ps
`include "pml_defines.vh"
module pml_top #(
  parameter DW         = 8,
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW    = 2,
  parameter DL_DEPTH   = 32
) (
  input  wire          clk_sys_i,
  input  wire          srst_i,
  input  wire          ce_i,
  input  wire [1:0]    speed_i,
  input  wire [1:0]    lat_sel_i,
  input  wire          half_duplex_i,
  input  wire          tx_en_i,
  input  wire          tx_er_i,
  input  wire [DW-1:0] txd_i,
  input  wire [3:0]    line_rx_carrier_i,
  input  wire          line_rx_data_en_i,
  input  wire          line_rx_valid_i,
  input  wire [DW-1:0] line_rx_data_i,
  output wire          line_rx_ready_o,
  output reg           crs_o,
  output reg           col_o,
  output reg           rx_dv_o,
  output reg  [DW-1:0] rxd_o,
  output reg           line_tx_en_o,
  output reg  [DW-1:0] line_tx_data_o,
  output reg           line_tx_sos_o,
  output reg           line_tx_eos_o,
  output reg  [1:0]    line_tx_end_kind_o
);
  localparam TXW = DW + 2;

  // tap numbers are cut to the delay-line index width on purpose
  function [4:0] pml_cut5;
    input integer v;
    begin
      pml_cut5 = v[4:0];
    end
  endfunction

  localparam [4:0] TX_TAP_1000 = pml_cut5(`PML_TX_1000_CYC - 1);
  localparam [4:0] TX_TAP_100  = pml_cut5(`PML_TX_100_CYC - 1);
  localparam [4:0] TX_TAP_10   = pml_cut5(`PML_TX_10_CYC - 1);
  localparam [4:0] LAT_STEP    = pml_cut5(`PML_LAT_STEP_CYC);

  localparam [4:0] RX1G_CRS_ON   = pml_cut5(`PML_RX1G_CRS_ON_CYC - 1);
  localparam [4:0] RX1G_CRS_OFF  = pml_cut5(`PML_RX1G_CRS_OFF_CYC - 1);
  localparam [4:0] RX1G_DV_ON    = pml_cut5(`PML_RX1G_DV_ON_CYC - 1);
  localparam [4:0] RX1G_DV_OFF   = pml_cut5(`PML_RX1G_DV_OFF_CYC - 1);
  localparam [4:0] RX100_CRS_ON  = pml_cut5(`PML_RX100_CRS_ON_CYC - 1);
  localparam [4:0] RX100_CRS_OFF = pml_cut5(`PML_RX100_CRS_OFF_CYC - 1);
  localparam [4:0] RX100_DV_ON   = pml_cut5(`PML_RX100_DV_ON_CYC - 1);
  localparam [4:0] RX100_DV_OFF  = pml_cut5(`PML_RX100_DV_OFF_CYC - 1);

  reg  [TXW-1:0]      tx_dl_q [0:DL_DEPTH-1];
  reg  [DL_DEPTH-1:0] rx_car_q;
  reg  [DL_DEPTH-1:0] rx_dat_q;
  reg  [4:0]          tx_tap;
  reg  [4:0]          crs_on_tap;
  reg  [4:0]          crs_off_tap;
  reg  [4:0]          dv_on_tap;
  reg  [4:0]          dv_off_tap;
  reg  [5:0]          pace_q;
  reg  [5:0]          pace_reload;
  reg  [1:0]          end_kind_d;
  wire [TXW-1:0]      tx_tap_w;
  wire                speed_1g;
  wire                rx_carrier_w;
  wire                rx_crs_w;
  wire                rx_dv_w;
  wire                pace_tick;
  wire                fifo_valid;
  wire                fifo_ready;
  wire [DW-1:0]       fifo_data;
  integer             i;

  function pml_pick;
    input [DL_DEPTH-1:0] v;
    input [4:0]          idx;
    begin
      pml_pick = v[idx];
    end
  endfunction

  assign speed_1g = (speed_i == `PML_SPEED_1000);

  // ---------------- transmit path ----------------
  always @* begin
    case (speed_i)
      `PML_SPEED_1000: tx_tap = TX_TAP_1000 + LAT_STEP * {3'h0, lat_sel_i};
      `PML_SPEED_100:  tx_tap = TX_TAP_100;
      default:         tx_tap = TX_TAP_10;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (i = 0; i < DL_DEPTH; i = i + 1) begin
        tx_dl_q[i] <= {TXW{1'b0}};
      end
    end else if (ce_i) begin
      tx_dl_q[0] <= {tx_en_i, tx_er_i, txd_i};
      for (i = 1; i < DL_DEPTH; i = i + 1) begin
        tx_dl_q[i] <= tx_dl_q[i-1];
      end
    end
  end

  assign tx_tap_w = tx_dl_q[tx_tap];

  // carrier extension is en low with er high; ext-error also carries a marker byte
  always @* begin
    end_kind_d = `PML_END_RESET;
    if (speed_1g & tx_tap_w[DW]) begin
      if (tx_tap_w[DW-1:0] == `PML_TXD_EXT_ERR) begin
        end_kind_d = `PML_END_EXT_ERR;
      end else begin
        end_kind_d = `PML_END_EXTEND;
      end
    end
  end

  // end timing holds only while line timing is locked to clk_sys_i; no drift absorption
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      line_tx_en_o       <= 1'b0;
      line_tx_data_o     <= {DW{1'b0}};
      line_tx_sos_o      <= 1'b0;
      line_tx_eos_o      <= 1'b0;
      line_tx_end_kind_o <= `PML_END_RESET;
    end else if (ce_i) begin
      line_tx_en_o   <= tx_tap_w[DW+1];
      line_tx_data_o <= tx_tap_w[DW-1:0];
      line_tx_sos_o  <= tx_tap_w[DW+1] & ~line_tx_en_o;
      line_tx_eos_o  <= ~tx_tap_w[DW+1] & line_tx_en_o;
      if (~tx_tap_w[DW+1] & line_tx_en_o) begin
        line_tx_end_kind_o <= end_kind_d;
      end
    end
  end

  // ---------------- receive path ----------------
  // gigabit waits for all four pairs so skew is measured from the latest
  assign rx_carrier_w = speed_1g ? &line_rx_carrier_i : line_rx_carrier_i[0];

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      rx_car_q <= {DL_DEPTH{1'b0}};
      rx_dat_q <= {DL_DEPTH{1'b0}};
    end else if (ce_i) begin
      rx_car_q <= {rx_car_q[DL_DEPTH-2:0], rx_carrier_w};
      rx_dat_q <= {rx_dat_q[DL_DEPTH-2:0], rx_carrier_w & line_rx_data_en_i};
    end
  end

  // 10 Mb/s receive is not modelled; it reuses the 100 Mb/s taps
  always @* begin
    if (speed_1g) begin
      crs_on_tap  = RX1G_CRS_ON;
      crs_off_tap = RX1G_CRS_OFF;
      dv_on_tap   = RX1G_DV_ON;
      dv_off_tap  = RX1G_DV_OFF;
    end else begin
      crs_on_tap  = RX100_CRS_ON;
      crs_off_tap = RX100_CRS_OFF;
      dv_on_tap   = RX100_DV_ON;
      dv_off_tap  = RX100_DV_OFF;
    end
  end

  // or of an early and a late tap: rises at the early one, falls at the late one
  assign rx_crs_w = pml_pick(rx_car_q, crs_on_tap) | pml_pick(rx_car_q, crs_off_tap);
  assign rx_dv_w  = pml_pick(rx_dat_q, dv_on_tap) | pml_pick(rx_dat_q, dv_off_tap);

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      crs_o   <= 1'b0;
      col_o   <= 1'b0;
      rx_dv_o <= 1'b0;
    end else if (ce_i) begin
      crs_o   <= tx_en_i | rx_crs_w;
      col_o   <= half_duplex_i & tx_en_i & rx_crs_w;
      rx_dv_o <= rx_dv_w;
    end
  end

  // ---------------- receive data buffer and pacing ----------------
  always @* begin
    case (speed_i)
      `PML_SPEED_1000: pace_reload = 6'h00;
      `PML_SPEED_100:  pace_reload = `PML_PACE_100;
      default:         pace_reload = `PML_PACE_10;
    endcase
  end

  assign pace_tick = (pace_q == 6'h00);

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      pace_q <= 6'h00;
    end else if (ce_i) begin
      pace_q <= pace_tick ? pace_reload : pace_q - 6'h01;
    end
  end

  // drain at mac word rate during dv; flush stale words once the line is idle
  assign fifo_ready = (pace_tick & rx_dv_o) | (~rx_dv_o & ~rx_crs_w & ~rx_carrier_w);

  pml_fifo #(
    .W  (DW),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_rx_fifo (
    .clk_i       (clk_sys_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .in_valid_i  (line_rx_valid_i),
    .in_ready_o  (line_rx_ready_o),
    .in_data_i   (line_rx_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready),
    .out_data_o  (fifo_data)
  );

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      rxd_o <= {DW{1'b0}};
    end else if (ce_i & fifo_valid & pace_tick & rx_dv_o) begin
      rxd_o <= fifo_data;
    end
  end
endmodule // pml_top

// [test/pml_top_checker.sv]
`timescale 1ns/10ps
module pml_top_checker (
  input wire       clk_sys_i,
  input wire       srst_i,
  input wire       ce_i,
  input wire [1:0] speed_i,
  input wire [1:0] lat_sel_i,
  input wire       tx_en_i,
  input wire [3:0] line_rx_carrier_i,
  input wire       line_rx_data_en_i,
  input wire       crs_o,
  input wire       rx_dv_o,
  input wire       line_tx_en_o,
  input wire       line_tx_sos_o,
  input wire       line_tx_eos_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i || !ce_i);
  wire gig   = speed_i == 2'h2;
  wire fast  = speed_i == 2'h1;
  wire all_c = &line_rx_carrier_i;
  // ns windows in 8 ns clocks, plus one as the output flop is seen an edge later
  property p_tx_crs; gig && $rose(tx_en_i) |-> ##[1:2] crs_o; endproperty
  a_tx_crs: assert property (p_tx_crs) else $error("crs late after tx enable");
  property p_sos_1g; gig && lat_sel_i == 2'h0 && $rose(tx_en_i) |-> ##11 line_tx_sos_o;
  endproperty
  a_sos_1g: assert property (p_sos_1g) else $error("gigabit start off time");
  property p_eos_1g; gig && lat_sel_i == 2'h0 && $fell(tx_en_i) |-> ##11 line_tx_eos_o;
  endproperty
  a_eos_1g: assert property (p_eos_1g) else $error("gigabit end off time");
  property p_lat3; gig && lat_sel_i == 2'h3 && $rose(tx_en_i) |-> ##14 $rose(line_tx_en_o);
  endproperty
  a_lat3: assert property (p_lat3) else $error("latency step wrong");
  property p_tx100; fast && $fell(tx_en_i) |-> ##[9:10] line_tx_eos_o; endproperty
  a_tx100: assert property (p_tx100) else $error("100 end delimiter off time");
  property p_tx10; speed_i == 2'h0 && $rose(tx_en_i) |-> ##[26:38] line_tx_sos_o; endproperty
  a_tx10: assert property (p_tx10) else $error("10 preamble off time");
  property p_rx1g_on; gig && $rose(all_c) |-> ##[21:24] crs_o; endproperty
  a_rx1g_on: assert property (p_rx1g_on) else $error("gigabit rx crs late");
  property p_rx1g_dv; gig && $rose(all_c && line_rx_data_en_i) |-> ##[23:27] rx_dv_o; endproperty
  a_rx1g_dv: assert property (p_rx1g_dv) else $error("gigabit rx dv late");
  property p_rx1g_off; gig && !tx_en_i && $fell(all_c) |-> ##[23:26] !crs_o; endproperty
  a_rx1g_off: assert property (p_rx1g_off) else $error("gigabit rx crs stuck");
  property p_rx100_on; fast && $rose(line_rx_carrier_i[0]) |-> ##[20:24] crs_o; endproperty
  a_rx100_on: assert property (p_rx100_on) else $error("100 rx crs late");
  property p_rx100_off; fast && !tx_en_i && $fell(line_rx_carrier_i[0]) |-> ##[25:29] !crs_o;
  endproperty
  a_rx100_off: assert property (p_rx100_off) else $error("100 rx crs stuck");
endmodule // pml_top_checker

bind pml_top pml_top_checker u_pml_top_checker (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i), .speed_i(speed_i),
  .lat_sel_i(lat_sel_i), .tx_en_i(tx_en_i), .line_rx_carrier_i(line_rx_carrier_i),
  .line_rx_data_en_i(line_rx_data_en_i), .crs_o(crs_o), .rx_dv_o(rx_dv_o),
  .line_tx_en_o(line_tx_en_o), .line_tx_sos_o(line_tx_sos_o), .line_tx_eos_o(line_tx_eos_o));

// [test/pml_mac_model.sv]
`timescale 1ns/10ps
module pml_mac_model (
  input wire       clk_i,
  input wire       rx_dv_i,
  input wire [7:0] rxd_i
);
  reg [7:0] got [0:7];
  reg [7:0] last_q = 8'h00;
  integer   cnt    = 0;
  // gmii cannot stall; a new word is told apart by its value changing
  always @(posedge clk_i) begin
    if (rx_dv_i === 1'b1 && rxd_i !== last_q && cnt < 8) begin
      got[cnt] <= rxd_i;
      last_q   <= rxd_i;
      cnt      <= cnt + 1;
    end
  end
endmodule // pml_mac_model

// [test/pml_top_tb.sv]
`timescale 1ns/10ps
module pml_top_tb;
  reg        clk_sys_i = 0, srst_i = 1, ce_i = 1, half_duplex_i = 0, tx_en_i = 0, tx_er_i = 0;
  reg        line_rx_data_en_i = 0, line_rx_valid_i = 0;
  reg  [1:0] speed_i = 2'h2, lat_sel_i = 2'h0;
  reg  [7:0] txd_i = 8'h00, line_rx_data_i = 8'h00;
  reg  [3:0] line_rx_carrier_i = 4'h0;
  wire       line_rx_ready_o, crs_o, col_o, rx_dv_o, line_tx_en_o, line_tx_sos_o, line_tx_eos_o;
  wire [7:0] rxd_o, line_tx_data_o;
  wire [1:0] line_tx_end_kind_o;
  integer    bad_count = 0, checks = 0, n;
  always #4 clk_sys_i = ~clk_sys_i;
  pml_top u_pml_top (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i), .speed_i(speed_i),
    .lat_sel_i(lat_sel_i), .half_duplex_i(half_duplex_i), .tx_en_i(tx_en_i), .tx_er_i(tx_er_i),
    .txd_i(txd_i), .line_rx_carrier_i(line_rx_carrier_i), .line_rx_data_en_i(line_rx_data_en_i),
    .line_rx_valid_i(line_rx_valid_i), .line_rx_data_i(line_rx_data_i),
    .line_rx_ready_o(line_rx_ready_o), .crs_o(crs_o), .col_o(col_o), .rx_dv_o(rx_dv_o),
    .rxd_o(rxd_o), .line_tx_en_o(line_tx_en_o), .line_tx_data_o(line_tx_data_o),
    .line_tx_sos_o(line_tx_sos_o), .line_tx_eos_o(line_tx_eos_o),
    .line_tx_end_kind_o(line_tx_end_kind_o));
  pml_mac_model u_pml_mac_model (.clk_i(clk_sys_i), .rx_dv_i(rx_dv_o), .rxd_i(rxd_o));

  task test_done; begin
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  end endtask
  task chk(input ok, input string m); begin
    checks = checks + 1;
    if (!ok) begin
      bad_count = bad_count + 1;
      $display("BAD %0t %s", $time, m);
    end
  end endtask
  // one clock, with n counting edges since the launching edge
  task edge_n; begin
    @(posedge clk_sys_i);
    #1;
    n = n + 1;
    if (n > 400) begin
      bad_count = bad_count + 1;
      $display("BAD %0t timeout", $time);
      test_done;
    end
  end endtask
  task t_tx(input [1:0] s, input [1:0] l, input er, input [7:0] d, input integer lo, hi,
            input [1:0] k); begin
    // drain the delay line so a new tap never replays the last frame
    repeat (32) @(negedge clk_sys_i);
    speed_i = s;
    lat_sel_i = l;
    tx_en_i = 1'b1;
    txd_i = 8'hA5;
    n = -1;
    edge_n;
    edge_n;
    chk(crs_o === 1'b1, "crs on");
    while (line_tx_en_o !== 1'b1) edge_n;
    chk(n*8 >= lo+8*l && n*8 <= hi+8*l && line_tx_sos_o === 1'b1, "start");
    chk(line_tx_data_o === 8'hA5, "data");
    @(negedge clk_sys_i);
    tx_en_i = 1'b0;
    tx_er_i = er;
    txd_i = d;
    n = -1;
    edge_n;
    edge_n;
    chk(crs_o === 1'b0, "crs off");
    while (line_tx_en_o !== 1'b0) edge_n;
    chk(n*8 >= lo+8*l && n*8 <= hi+8*l && line_tx_eos_o === 1'b1, "end");
    chk(line_tx_end_kind_o === k, "end kind");
    @(negedge clk_sys_i);
    tx_er_i = 1'b0;
    $display("tx test done");
  end endtask
  task meas(input lvl, output integer a, output integer b); begin
    a = 0;
    b = 0;
    n = -1;
    edge_n;
    while (a == 0 || b == 0) begin
      edge_n;
      if (a == 0 && crs_o === lvl) a = n;
      if (b == 0 && rx_dv_o === lvl) b = n;
    end
  end endtask
  task t_rx(input [1:0] s, input [3:0] pre, input integer a0, a1, b0, b1, c0, c1, d0, d1);
    integer a, b;
    begin
      @(negedge clk_sys_i);
      speed_i = s;
      line_rx_carrier_i = pre;
      // skewed pairs: timing runs from the last one to arrive
      repeat (3) @(negedge clk_sys_i);
      line_rx_carrier_i = 4'hF;
      line_rx_data_en_i = 1'b1;
      meas(1'b1, a, b);
      chk(a*8 >= a0 && a*8 <= a1 && b*8 >= b0 && b*8 <= b1, "rx on");
      @(negedge clk_sys_i);
      line_rx_carrier_i = 4'h0;
      line_rx_data_en_i = 1'b0;
      meas(1'b0, a, b);
      chk(a*8 >= c0 && a*8 <= c1 && b*8 >= d0 && b*8 <= d1, "rx off");
      $display("rx test done");
    end
  endtask
  task t_col; begin
    @(negedge clk_sys_i);
    speed_i = 2'h2;
    half_duplex_i = 1'b1;
    line_rx_carrier_i = 4'hF;
    n = -1;
    while (crs_o !== 1'b1) edge_n;
    chk(col_o === 1'b0, "col without tx");
    @(negedge clk_sys_i);
    tx_en_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk(col_o === 1'b1, "col on");
    @(negedge clk_sys_i);
    tx_en_i = 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk(col_o === 1'b0, "col off");
    @(negedge clk_sys_i);
    line_rx_carrier_i = 4'h0;
    half_duplex_i = 1'b0;
    repeat (40) @(negedge clk_sys_i);
    $display("col test done");
  end endtask
  task t_fifo;
    integer k;
    begin
      @(negedge clk_sys_i);
      speed_i = 2'h2;
      line_rx_carrier_i = 4'hF;
      line_rx_data_en_i = 1'b1;
      k = 0;
      while (line_rx_ready_o === 1'b1 && k < 6) begin
        line_rx_valid_i = 1'b1;
        line_rx_data_i = 8'h30 + k[7:0];
        k = k + 1;
        @(negedge clk_sys_i);
      end
      chk(k == 4, "fifo depth");
      line_rx_data_i = 8'hEE;
      @(negedge clk_sys_i);
      line_rx_valid_i = 1'b0;
      n = -1;
      while (u_pml_mac_model.cnt < 4) edge_n;
      repeat (4) edge_n;
      for (k = 0; k < 4; k = k + 1) chk(u_pml_mac_model.got[k] === 8'h30 + k[7:0], "fifo word");
      chk(u_pml_mac_model.cnt == 4 && line_rx_ready_o === 1'b1, "fifo drained");
      @(negedge clk_sys_i);
      line_rx_carrier_i = 4'h0;
      line_rx_data_en_i = 1'b0;
      $display("fifo test done");
    end
  endtask

  initial begin
    repeat (12) @(negedge clk_sys_i);
    srst_i = 1'b0;
    t_tx(2'h2, 2'h0, 1'b0, 8'h00, 76, 84, 2'h0);
    t_tx(2'h2, 2'h3, 1'b1, 8'h0F, 76, 84, 2'h1);
    t_tx(2'h2, 2'h1, 1'b1, 8'h1F, 76, 84, 2'h2);
    t_tx(2'h1, 2'h0, 1'b1, 8'h1F, 64, 72, 2'h0);
    t_tx(2'h0, 2'h0, 1'b0, 8'h00, 200, 300, 2'h0);
    t_rx(2'h2, 4'h7, 156, 188, 176, 208, 172, 204, 176, 208);
    t_rx(2'h1, 4'h0, 152, 184, 216, 248, 192, 224, 216, 248);
    t_col;
    t_fifo;
    test_done;
  end
endmodule // pml_top_tb
